/* File: shared/csg_pkg.sv */
// constants and carrier types for the charge sequence timeout guard
// assumes a single 125 MHz core clock; host commands are one-cycle pulses
// Function
// RL1: any sequence timer expiry aborts the sequence or blocks charging.
// RL2: host loads timer settings; unset timers use built-in defaults.
// RL3: charge timer preset 180 s, counts seconds from charge start, aborts at zero.
// RL4: hold timer starts once every enabled charger reports charge complete.
// RL5: hold timer cleared and stopped by host arm request.
// RL6: hold limit 0..60 s default 60; expiry before arm aborts.
// RL7: arm request starts trigger wait and enters the armed state.
// RL8: sync trigger pulse clears and stops the trigger wait.
// RL9: trigger wait limit 0..20 s default 20; expiry aborts.
// RL10: nonzero charge delay counts down from charge command before charging.
// RL11: charge delay at zero, expired or unset, enters charging.
// RL12: charge delay settable 0..180 s, default 0 s.
// RL13: dump relay energized only while charging is permitted.
// RL14: any open door refuses entry to charging.
// RL15: door opening while charging or charged aborts at once.
// RL16: listed hardware faults abort charging automatically.
// RL17: after fire or abort, report then return to on-line.
// RL18: one-second tick from clock; timers load settings on start.
// RL19: abort stops timers, disables chargers, drops relay, reports cause.
package csg_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_SEC = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;
	localparam int NUM_CHARGERS = 12;
	localparam int TMR_W = 8;
	localparam logic [TMR_W-1:0] CHARGE_TIME_S = 8'hB4;
	localparam logic [TMR_W-1:0] HOLD_MAX_S = 8'h3C;
	localparam logic [TMR_W-1:0] HOLD_DEF_S = 8'h3C;
	localparam logic [TMR_W-1:0] TRIG_MAX_S = 8'h14;
	localparam logic [TMR_W-1:0] TRIG_DEF_S = 8'h14;
	localparam logic [TMR_W-1:0] DELAY_MAX_S = 8'hB4;
	localparam logic [TMR_W-1:0] DELAY_DEF_S = 8'h00;

	typedef enum logic [1:0] {
		CSG_SEL_HOLD,
		CSG_SEL_TRIG,
		CSG_SEL_DELAY,
		CSG_SEL_NONE
	} csg_sel_t;

	// host command pulses
	typedef struct packed {
		logic charge;
		logic arm_request;
		logic abort;
		logic set_valid;
		csg_sel_t set_sel;
		logic [TMR_W-1:0] set_value;
		logic report_done;
	} csg_cmd_t;

	// fault inputs from the unit hardware
	typedef struct packed {
		logic relay_misposition;
		logic amp_ctrl_lost;
		logic charger_no_enable;
		logic ramp_slow;
		logic ramp_fast;
		logic ramp_falling;
		logic over_volt;
		logic under_volt;
		logic prefire;
	} csg_fault_t;

	typedef struct packed {
		logic timer_charge;
		logic timer_hold;
		logic timer_trig;
		logic door;
		logic hw_fault;
		logic host_cmd;
	} csg_cause_t;
endpackage : csg_pkg

/* File: design/csg_guard.sv */
// charge-and-fire sequencer with timeout guards and door interlock
// assumes host commands are same-clock pulses; pins pass synchronisers
`timescale 1ns/100ps
module csg_guard
	import csg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire csg_cmd_t cmd,
	input wire logic [NUM_CHARGERS-1:0] charger_sel,
	input wire logic [NUM_CHARGERS-1:0] charge_complete_signal,
	input wire logic sync_trigger,
	input wire logic [1:0] door_open,
	input wire csg_fault_t fault,
	output logic [NUM_CHARGERS-1:0] charger_en,
	output logic relay_energize,
	output logic fire_enable,
	output logic armed,
	output logic abort_pulse,
	output csg_cause_t abort_cause,
	output logic report_req,
	output logic online,
	output logic [TMR_W-1:0] charge_remain
);

	typedef enum logic [2:0] {
		CSG_ONLINE,
		CSG_DELAY,
		CSG_CHARGING,
		CSG_HOLD,
		CSG_ARMED,
		CSG_REPORT
	} csg_state_t;

	function automatic logic [TMR_W-1:0] csg_clamp(
		input logic [TMR_W-1:0] v,
		input logic [TMR_W-1:0] lim
	);
		csg_clamp = (v > lim) ? lim : v;
	endfunction : csg_clamp

	////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	localparam int NSYNC = NUM_CHARGERS + 3 + 9;
	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	assign sync_in = {charge_complete_signal, sync_trigger, door_open, fault};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= sync_in;
			s2_q <= s1_q;
		end
	end

	logic [NUM_CHARGERS-1:0] eoc_s;
	logic trig_s;
	logic [1:0] door_s;
	csg_fault_t fault_s;
	assign {eoc_s, trig_s, door_s, fault_s} = s2_q;

	logic trig_last_q;
	logic trig_rise;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trig_last_q <= 1'b0;
		end else begin
			trig_last_q <= trig_s;
		end
	end
	assign trig_rise = trig_s & ~trig_last_q;

	////////////////////////////////////////////////////////////////////
	// one-second tick divider
	logic [26:0] div_q;
	logic [26:0] div_d;
	logic tick;
	always_comb begin
		tick = (div_q == 27'(TICK_CYCLES - 1)); // RL18
		div_d = tick ? '0 : div_q + 27'd1;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// host timer settings, reset to defaults
	logic [TMR_W-1:0] hold_set_q, hold_set_d;
	logic [TMR_W-1:0] trig_set_q, trig_set_d;
	logic [TMR_W-1:0] delay_set_q, delay_set_d;

	always_comb begin
		hold_set_d = hold_set_q;
		trig_set_d = trig_set_q;
		delay_set_d = delay_set_q;
		if (cmd.set_valid) begin // RL2
			case (cmd.set_sel)
				CSG_SEL_HOLD: hold_set_d = csg_clamp(cmd.set_value, HOLD_MAX_S); // RL6
				CSG_SEL_TRIG: trig_set_d = csg_clamp(cmd.set_value, TRIG_MAX_S); // RL9
				CSG_SEL_DELAY: delay_set_d = csg_clamp(cmd.set_value,
					DELAY_MAX_S); // RL12
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hold_set_q <= HOLD_DEF_S;
			trig_set_q <= TRIG_DEF_S;
			delay_set_q <= DELAY_DEF_S; // RL12
		end else begin
			hold_set_q <= hold_set_d;
			trig_set_q <= trig_set_d;
			delay_set_q <= delay_set_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencer and countdowns
	csg_state_t st_q, st_d;
	logic [TMR_W-1:0] chg_q, chg_d;
	logic [TMR_W-1:0] phase_q, phase_d;
	logic [NUM_CHARGERS-1:0] en_q, en_d;
	logic relay_q, relay_d;
	logic abort_q, abort_d;
	csg_cause_t cause_q, cause_d;
	logic report_q, report_d;
	logic any_door;
	logic any_fault;
	logic all_eoc;
	logic go_abort;
	csg_cause_t why;

	assign any_door = |door_s;
	assign any_fault = |fault_s;
	assign all_eoc = ((eoc_s & en_q) == en_q) && (|en_q);

	always_comb begin
		st_d = st_q;
		chg_d = chg_q;
		phase_d = phase_q;
		en_d = en_q;
		relay_d = 1'b0;
		abort_d = 1'b0;
		cause_d = cause_q;
		report_d = 1'b0;
		why = '0;
		go_abort = 1'b0;
		case (st_q)
			CSG_ONLINE: begin
				if (cmd.charge && !any_door && !any_fault) begin // RL14
					if (delay_set_q != '0) begin
						st_d = CSG_DELAY; // RL10
						phase_d = delay_set_q; // RL18
					end else begin
						st_d = CSG_CHARGING; // RL11
						chg_d = CHARGE_TIME_S; // RL3
						en_d = charger_sel;
					end
				end
			end
			CSG_DELAY: begin
				if (phase_q == '0) begin
					if (any_door) begin
						st_d = CSG_ONLINE; // RL14
					end else begin
						st_d = CSG_CHARGING; // RL11
						chg_d = CHARGE_TIME_S; // RL3
						en_d = charger_sel;
					end
				end else if (tick) begin
					phase_d = phase_q - 8'd1; // RL10
				end
			end
			CSG_CHARGING: begin
				relay_d = 1'b1; // RL13
				if (all_eoc) begin
					st_d = CSG_HOLD; // RL4
					phase_d = hold_set_q; // RL18
				end else if (chg_q == '0) begin
					go_abort = 1'b1; // RL3
					why.timer_charge = 1'b1; // RL1
				end else if (tick) begin
					chg_d = chg_q - 8'd1; // RL3
				end
			end
			CSG_HOLD: begin
				relay_d = 1'b1; // RL13
				if (cmd.arm_request) begin
					st_d = CSG_ARMED; // RL5 RL7
					phase_d = trig_set_q; // RL18
				end else if (phase_q == '0) begin
					go_abort = 1'b1; // RL6
					why.timer_hold = 1'b1; // RL1
				end else if (tick) begin
					phase_d = phase_q - 8'd1;
				end
			end
			CSG_ARMED: begin
				relay_d = 1'b1; // RL13
				if (trig_rise) begin
					st_d = CSG_REPORT; // RL8 RL17
					phase_d = '0;
					en_d = '0;
					relay_d = 1'b0;
				end else if (phase_q == '0) begin
					go_abort = 1'b1; // RL9
					why.timer_trig = 1'b1; // RL1
				end else if (tick) begin
					phase_d = phase_q - 8'd1;
				end
			end
			CSG_REPORT: begin
				report_d = 1'b1; // RL17
				if (cmd.report_done) begin
					st_d = CSG_ONLINE; // RL17
				end
			end
			default: st_d = CSG_ONLINE;
		endcase
		// fault or host abort overrides timers in active states; door only in charging, hold and armed
		if (st_q == CSG_CHARGING || st_q == CSG_HOLD || st_q == CSG_ARMED
			|| st_q == CSG_DELAY) begin
			if (any_door && st_q != CSG_DELAY) begin
				go_abort = 1'b1; // RL15
				why.door = 1'b1;
			end
			if (any_fault) begin
				go_abort = 1'b1; // RL16
				why.hw_fault = 1'b1;
			end
			if (cmd.abort) begin
				go_abort = 1'b1;
				why.host_cmd = 1'b1;
			end
		end
		if (go_abort) begin
			st_d = CSG_REPORT; // RL19
			phase_d = '0;
			chg_d = '0;
			en_d = '0;
			relay_d = 1'b0; // RL13
			abort_d = 1'b1;
			cause_d = why;
		end
		if (st_d == CSG_ONLINE || st_d == CSG_DELAY) begin
			en_d = '0;
		end
		if (st_q == CSG_ONLINE && st_d != CSG_ONLINE) begin
			cause_d = '0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= CSG_ONLINE;
			chg_q <= CHARGE_TIME_S;
			phase_q <= '0;
			en_q <= '0;
			relay_q <= 1'b0;
			abort_q <= 1'b0;
			cause_q <= '0;
			report_q <= 1'b0;
		end else begin
			st_q <= st_d;
			chg_q <= chg_d;
			phase_q <= phase_d;
			en_q <= en_d;
			relay_q <= relay_d;
			abort_q <= abort_d;
			cause_q <= cause_d;
			report_q <= report_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs
	logic armed_q;
	logic online_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			armed_q <= 1'b0;
			online_q <= 1'b1;
		end else begin
			armed_q <= (st_d == CSG_ARMED);
			online_q <= (st_d == CSG_ONLINE);
		end
	end

	assign charger_en = en_q;
	assign relay_energize = relay_q;
	assign fire_enable = armed_q;
	assign armed = armed_q;
	assign abort_pulse = abort_q;
	assign abort_cause = cause_q;
	assign report_req = report_q;
	assign online = online_q;
	assign charge_remain = chg_q;

endmodule : csg_guard

/* File: tb/csg_far.sv */
// charger bank and trigger link model
// eoc after ramp cycles of enable; fire held by bench
`timescale 1ns/100ps
module csg_far
	import csg_pkg::*;
(
	input wire logic core_clk,
	input wire logic [NUM_CHARGERS-1:0] charger_en,
	input wire logic [3:0] ramp,
	input wire logic fire,
	output logic [NUM_CHARGERS-1:0] charge_complete_signal = '0,
	output logic sync_trigger = 1'b0
);
	logic [3:0] age_q = 4'h0;
	// a disabled charger reports no charge_complete_signal
	always @(posedge core_clk) begin
		age_q <= (charger_en == '0) ? 4'h0 : age_q + {3'h0, age_q != ramp};
		charge_complete_signal <= (age_q == ramp) ? charger_en : '0;
		sync_trigger <= fire;
	end
endmodule : csg_far

/* File: tb/csg_guard_properties.sv */
// port-level checks of the timeout guard
// bound onto csg_guard below
`timescale 1ns/100ps
module csg_chk
	import csg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire csg_cmd_t cmd,
	input wire logic [1:0] door_open,
	input wire logic sync_trigger,
	input wire logic [NUM_CHARGERS-1:0] charger_en,
	input wire logic relay_energize,
	input wire logic armed,
	input wire logic abort_pulse,
	input wire csg_cause_t abort_cause,
	input wire logic report_req,
	input wire logic online
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////
	sequence s_safe; charger_en == '0 && !relay_energize && !armed; endsequence
	sequence s_door; (door_open != 2'h0) [*4]; endsequence
	property p_safe; abort_pulse |-> ##[0:1] s_safe; endproperty
	property p_cause; abort_pulse |-> ##[0:1] abort_cause != '0; endproperty
	property p_relay; relay_energize |-> !online; endproperty
	property p_refuse;
		s_door ##0 (online && cmd.charge) |=> (charger_en == '0) [*2];
	endproperty
	property p_door; $rose(|door_open) && |charger_en |-> ##[1:5] abort_pulse;
	endproperty
	property p_arm; $rose(armed) |-> $past(cmd.arm_request); endproperty
	property p_trig;
		armed && $rose(sync_trigger) |-> ##[1:6] report_req && !relay_energize;
	endproperty
	property p_rep; $fell(report_req) |-> online; endproperty
	a_safe: assert property (p_safe) else $error("unsafe after abort");
	a_cause: assert property (p_cause) else $error("no cause");
	a_relay: assert property (p_relay) else $error("relay online");
	a_refuse: assert property (p_refuse) else $error("door charge");
	a_door: assert property (p_door) else $error("no door abort");
	a_arm: assert property (p_arm) else $error("armed unasked");
	a_trig: assert property (p_trig) else $error("trigger lost");
	a_rep: assert property (p_rep) else $error("not online");
endmodule : csg_chk
bind csg_guard csg_chk u_chk (.core_clk, .rstn, .cmd, .door_open,
	.sync_trigger, .charger_en, .relay_energize, .armed, .abort_pulse,
	.abort_cause, .report_req, .online);

/* File: tb/testbench.sv */
// command-sequence bench for csg_guard
// second-long timers cannot run out here; zero limits stand in
`timescale 1ns/100ps
module testbench
	import csg_pkg::*;
;
	localparam logic [14:0] CHG = 15'h4000, ARM = 15'h2000;
	localparam logic [14:0] ABT = 15'h1000, DONE = 15'h0001;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	csg_cmd_t cmd = '0;
	logic [NUM_CHARGERS-1:0] charger_sel = 12'h0005;
	logic [1:0] door_open = 2'h0;
	csg_fault_t fault = '0;
	logic fire = 1'b0;
	logic [3:0] ramp = 4'h2;
	logic [NUM_CHARGERS-1:0] eoc, charger_en;
	logic sync_trigger, relay_energize, armed, abort_pulse, report_req, online;
	logic fire_enable;
	csg_cause_t abort_cause;
	logic [TMR_W-1:0] charge_remain;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #4 core_clk = ~core_clk;
	csg_guard DUT (.core_clk, .rstn, .cmd, .charger_sel,
		.charge_complete_signal(eoc), .sync_trigger, .door_open, .fault,
		.charger_en, .relay_energize, .fire_enable, .armed, .abort_pulse,
		.abort_cause, .report_req, .online, .charge_remain);
	csg_far far (.core_clk, .charger_en, .ramp, .fire,
		.charge_complete_signal(eoc), .sync_trigger);
	////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [14:0] c);
		@(negedge core_clk);
		cmd = csg_cmd_t'(c);
		@(negedge core_clk);
		cmd = '0;
	endtask : send
	task automatic setv(input csg_sel_t s, input logic [7:0] v);
		send({3'h0, 1'b1, s, v, 1'b0});
	endtask : setv
	task automatic wait_rep();
		for (int i = 0; i < 60 && report_req !== 1'b1; i++)
			@(negedge core_clk);
	endtask : wait_rep
	task automatic done();
		chk(report_req, 1'b1);
		send(DONE);
		chk(online, 1'b1);
	endtask : done
	task automatic finish_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// hang guard, the whole run needs about two hundred and forty cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		chk({charge_remain, online, relay_energize}, 10'h2D2);
		send(CHG);
		repeat (3) @(negedge core_clk);
		chk({relay_energize, charger_en}, 13'h1005);
		chk(charge_remain, CHARGE_TIME_S);
		repeat (15) @(negedge core_clk);
		send(ARM);
		chk({armed, fire_enable}, 2'h3);
		fire = 1'b1;
		repeat (3) @(negedge core_clk);
		fire = 1'b0;
		wait_rep();
		chk({relay_energize, charger_en}, 13'h0000);
		done();
		setv(CSG_SEL_HOLD, 8'h00);
		send(CHG);
		wait_rep();
		chk({relay_energize, charger_en, abort_cause, charge_remain},
			27'h000_1000);
		done();
		setv(CSG_SEL_HOLD, 8'hFF);
		setv(CSG_SEL_TRIG, 8'h00);
		send(CHG);
		repeat (15) @(negedge core_clk);
		send(ARM);
		wait_rep();
		chk({armed, abort_cause}, 7'h08);
		done();
		setv(CSG_SEL_TRIG, 8'h14);
		setv(CSG_SEL_DELAY, 8'h05);
		send(CHG);
		repeat (20) @(negedge core_clk);
		chk({online, charger_en}, 13'h0000);
		send(ABT);
		wait_rep();
		chk(abort_cause, 6'h01);
		done();
		setv(CSG_SEL_DELAY, 8'h00);
		door_open = 2'h2;
		repeat (4) @(negedge core_clk);
		send(CHG);
		repeat (3) @(negedge core_clk);
		chk({online, charger_en}, 13'h1000);
		door_open = 2'h0;
		repeat (4) @(negedge core_clk);
		send(CHG);
		repeat (15) @(negedge core_clk);
		door_open = 2'h1;
		wait_rep();
		chk(abort_cause, 6'h04);
		door_open = 2'h0;
		done();
		ramp = 4'hF;
		for (int i = 0; i < 9; i++) begin
			send(CHG);
			repeat (3) @(negedge core_clk);
			fault = csg_fault_t'(9'h001 << i);
			wait_rep();
			chk({relay_energize, abort_cause}, 7'h02);
			fault = '0;
			done();
		end
		finish_test();
	end
endmodule : testbench
